// *** dv/directional_earth_fault_config_tb.sv ***
// Purpose: Self-checking bench of the earth-fault configuration block
// Assumes: Clock enable held high
// Notes: Waits cover the three cycle pin path plus the feeder model
`timescale 1ns/1ps
`include "earth_fault_defs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end

module directional_earth_fault_config_tb;
	import earth_fault_pkg::*;
	logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, low_f = 0;
	logic external_characteristic_control_i = 0, high_f = 0;
	logic step_button_i = 0, reset_button_i = 0;
	logic [3:0] reg_addr_i = 0;
	logic [7:0] reg_wdata_i = 0, reg_rdata_o, u0_threshold_o;
	logic [7:0] low_time_setting_o, high_start_setting_o;
	logic low_stage_operate_i, high_stage_operate_i, trip_output_one_o;
	logic trip_output_two_o, sine_mode_o, high_stage_enable_o;
	logic erase_records_o, irq_o;
	int failures = 0, check_count = 0, cyc = 0, erase_n = 0;
	logic [7:0] lraw [4] = '{8'h00, 8'h05, 8'h14, 8'hc8};
	logic [7:0] hraw [4] = '{8'h00, 8'h03, 8'h14, 8'hff};
	logic [7:0] u0tab [4] = '{8'h02, 8'h05, 8'h0a, 8'h14};
	logic [7:0] rdat;
	logic [7:0] lexp [2][4] = '{'{8'h01, 8'h05, 8'h0a, 8'h0a},
		'{8'h0a, 8'h0a, 8'h14, 8'h64}};
	logic [7:0] hexp [2][4] = '{'{8'h05, 8'h05, 8'h14, 8'hff},
		'{8'h01, 8'h03, 8'h08, 8'hff}};

	directional_earth_fault_config DUT (.clk_i, .rst_i, .ce_i(1'b1),
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.external_characteristic_control_i, .step_button_i, .reset_button_i,
		.low_stage_operate_i, .high_stage_operate_i, .trip_output_one_o,
		.trip_output_two_o, .sine_mode_o, .high_stage_enable_o,
		.u0_threshold_o, .low_time_setting_o, .high_start_setting_o,
		.erase_records_o, .irq_o);
	feeder_relay_model feeder (.clk_i, .low_fault_i(low_f),
		.high_fault_i(high_f), .low_operate_o(low_stage_operate_i),
		.high_operate_o(high_stage_operate_i));

	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc++;
		erase_n += int'(erase_records_o);
		if (cyc == 3000)
		begin
			failures++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////
	task conclude;
		if (failures == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
		@(posedge clk_i);
		reg_wr_i <= 0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		{reg_rd_i, reg_addr_i} <= {1'b1, a};
		@(posedge clk_i);
		reg_rd_i <= 0;
		#1 d = reg_rdata_o;
	endtask : rd
	task w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : w
	////////////////////////////////////////////////////////////////////
	task t_char;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_i) external_characteristic_control_i <= i[2];
			wr(`OFS_SWITCH, {5'h00, i[1], i[0], 1'b0});
			w(5);
			`CHK("sine", i[0] ? i[2] : i[1], sine_mode_o)
		end
	endtask : t_char
	task t_u0;
		for (int i = 0; i < 4; i++)
		begin
			wr(`OFS_SWITCH, {i[1:0], 6'h00});
			w(4);
			`CHK("u0", u0tab[i], u0_threshold_o)
			rd(`OFS_DECODE, rdat);
			`CHK("u0_rd", u0tab[i], rdat)
		end
	endtask : t_u0
	task t_ranges;
		for (int s = 0; s < 2; s++)
			for (int k = 0; k < 4; k++)
			begin
				wr(`OFS_SWITCH, {2'b00, s[0], s[0], 4'h0});
				wr(4'h7, lraw[k]);
				wr(`OFS_SETTING, hraw[k]);
				@(posedge clk_i) high_f <= 1;
				w(6);
				`CHK("low", lexp[s][k], low_time_setting_o)
				`CHK("high", hexp[s][k], high_start_setting_o)
				`CHK("hs_trip", k != 3, trip_output_two_o)
				high_f <= 0;
				rd(4'h7, rdat);
				`CHK("low_raw", lraw[k], rdat)
				rd(`OFS_SETTING, rdat);
				`CHK("low_rd", lexp[s][k], rdat)
			end
		wr(`OFS_SETTING, 8'h14);
	endtask : t_ranges
	task t_latch;
		wr(`OFS_SWITCH, 8'h00);
		@(posedge clk_i) low_f <= 1;
		w(6);
		`CHK("trip1", 1'b1, trip_output_one_o)
		low_f <= 0;
		w(6);
		`CHK("trip1", 1'b0, trip_output_one_o)
		wr(`OFS_CLEAR, 8'h0f);
		wr(`OFS_ENABLE, 8'h03);
		wr(`OFS_SWITCH, 8'h08);
		@(posedge clk_i) {low_f, high_f} <= 2'b11;
		w(6);
		{low_f, high_f} <= 2'b00;
		w(8);
		`CHK("held", 2'b11, {trip_output_one_o, trip_output_two_o})
		`CHK("irq", 1'b1, irq_o)
		wr(`OFS_COMMAND, 8'h01);
		w(4);
		`CHK("cmd", 2'b00, {trip_output_one_o, trip_output_two_o})
		@(posedge clk_i) low_f <= 1;
		w(6);
		low_f <= 0;
		w(8);
		`CHK("held", 1'b1, trip_output_one_o)
		@(posedge clk_i) {step_button_i, reset_button_i} <= 2'b11;
		w(6);
		@(posedge clk_i) {step_button_i, reset_button_i} <= 2'b00;
		w(6);
		`CHK("btn", 1'b0, trip_output_one_o)
		`CHK("erase", 1, erase_n)
		rd(`OFS_STATUS, rdat);
		`CHK("status", 8'h0f, rdat)
		wr(`OFS_ENABLE, 8'h00);
		w(2);
		`CHK("masked", 1'b0, irq_o)
		wr(`OFS_CLEAR, 8'h0f);
		wr(`OFS_ENABLE, 8'h0f);
		w(2);
		`CHK("cleared", 1'b0, irq_o)
		rd(`OFS_STATUS, rdat);
		`CHK("status_clr", 8'h00, rdat)
	endtask : t_latch
	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		w(1);
		`CHK("rst", {8'h02, 8'h01, 8'h05}, {u0_threshold_o,
			low_time_setting_o, high_start_setting_o})
		rd(4'h8, rdat);
		`CHK("unmapped", 8'h00, rdat)
		t_char();
		t_u0();
		t_ranges();
		t_latch();
		conclude();
	end
endmodule : directional_earth_fault_config_tb

bind directional_earth_fault_config earth_fault_chk u_chk (.clk_i, .rst_i,
	.ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.external_characteristic_control_i, .step_button_i, .reset_button_i,
	.low_stage_operate_i, .trip_output_one_o, .trip_output_two_o,
	.sine_mode_o, .high_stage_enable_o, .u0_threshold_o,
	.low_time_setting_o, .high_start_setting_o, .erase_records_o);

// *** dv/earth_fault_chk.sv ***
// Purpose: Port checker for the earth-fault configuration block
// Assumes: Pin paths take three cycles to an output
// Notes: Switch image is mirrored from bus writes
`timescale 1ns/1ps
`include "earth_fault_defs.svh"

module earth_fault_chk
	import earth_fault_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic external_characteristic_control_i,
	input wire logic step_button_i,
	input wire logic reset_button_i,
	input wire logic low_stage_operate_i,
	input wire logic trip_output_one_o,
	input wire logic trip_output_two_o,
	input wire logic sine_mode_o,
	input wire logic high_stage_enable_o,
	input wire logic [7:0] u0_threshold_o,
	input wire logic [7:0] low_time_setting_o,
	input wire logic [7:0] high_start_setting_o,
	input wire logic erase_records_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] sw_q;
	logic [3:0] age_q;
	wire any_wr = reg_wr_i && ce_i;
	wire sw_wr = any_wr && reg_addr_i == `OFS_SWITCH;
	wire [7:0] u0_exp = sw_q[7] ? (sw_q[6] ? 8'h14 : 8'h0a)
		: (sw_q[6] ? 8'h05 : 8'h02);
	////////////////////////////////////////////////////////////////////
	// Any write restarts the settle count, so writes never race checks
	always_ff @(posedge clk_i)
	begin
		sw_q <= rst_i ? `RST_SWITCH : (sw_wr ? reg_wdata_i : sw_q);
		age_q <= (rst_i || any_wr) ? 4'h0 : age_q + 4'((age_q != 4'hf));
	end
	////////////////////////////////////////////////////////////////////
	AST_READ_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	AST_CHAR_MANUAL: assert property (
		age_q >= 4 && !sw_q[`SW_EXT_BIT] |-> sine_mode_o == sw_q[`SW_SIN_BIT])
		else $error("manual characteristic wrong");
	AST_CHAR_EXT: assert property (age_q >= 2 && sw_q[`SW_EXT_BIT] |->
		sine_mode_o == $past(external_characteristic_control_i, 3))
		else $error("external characteristic wrong");
	AST_NO_LATCH: assert property (age_q >= 8 && !sw_q[`SW_LATCH_BIT] |->
		trip_output_one_o == $past(low_stage_operate_i, 3))
		else $error("unlatched trip does not follow cause");
	AST_LATCH_HOLD: assert property (age_q >= 8 && sw_q[`SW_LATCH_BIT] &&
		$past(trip_output_one_o) && !$past(reset_button_i, 3) &&
		!$past(reset_button_i, 4) |-> trip_output_one_o)
		else $error("latched trip dropped");
	AST_ERASE: assert property (erase_records_o |->
		$past(step_button_i, 3) && $past(reset_button_i, 3)
		##1 !erase_records_o)
		else $error("erase pulse wrong");
	AST_TIME_RANGE: assert property (age_q >= 4 |-> (
		sw_q[`SW_TRANGE_BIT] ? low_time_setting_o inside {[8'h0a:8'h64]}
		: low_time_setting_o inside {[8'h01:8'h0a]}))
		else $error("low time out of range");
	AST_HIGH_RANGE: assert property (age_q >= 4 |-> (
		high_start_setting_o == `HSET_INFINITE || (sw_q[`SW_HRANGE_BIT] ?
		high_start_setting_o inside {[8'h01:8'h08]}
		: high_start_setting_o inside {[8'h05:8'h28]})))
		else $error("high start out of range");
	AST_U0: assert property (age_q >= 4 |-> u0_threshold_o == u0_exp)
		else $error("residual threshold wrong");
	AST_HIGH_OFF: assert property (age_q >= 8 |->
		high_stage_enable_o == (high_start_setting_o != `HSET_INFINITE) &&
		(high_stage_enable_o || !trip_output_two_o))
		else $error("infinite high stage active");
	cover property (erase_records_o);
	cover property (trip_output_one_o && sw_q[`SW_LATCH_BIT]);
	cover property (!high_stage_enable_o);
endmodule : earth_fault_chk

// *** dv/feeder_relay_model.sv ***
// Purpose: Far side model, the feeder measurement front end
// Assumes: Fault levels are commanded by the bench
// Notes: One register stage, like a slow comparator
`timescale 1ns/1ps

module feeder_relay_model
(
	input wire logic clk_i,
	input wire logic low_fault_i,
	input wire logic high_fault_i,
	output logic low_operate_o,
	output logic high_operate_o
);
	always_ff @(posedge clk_i)
	begin
		low_operate_o <= low_fault_i;
		high_operate_o <= high_fault_i;
	end
endmodule : feeder_relay_model

// *** hdl/directional_earth_fault_config.sv ***
// Purpose: Selector switch decode and trip-latch logic of a directional
//          neutral overcurrent relay stage
// Assumes: Pins and pushbuttons are asynchronous and debounced elsewhere
// Notes: Register port with read data one cycle after the read strobe
//
// Behaviour
// - Switch two hands characteristic to external input, else switch three picks sine
// - Latch off: trip outputs follow the start condition of their stage
// - Latch on: trip outputs hold until an explicit clear
// - Clear latched trips by both pushbuttons together or remote clear command
// - Both pushbuttons together also erase recorded measurement values
// - Low time switch clear: low-set operate time range 0.1 to 1.0 s
// - Low time switch set: low-set operate time range 1 to 10 s
// - High range switch clear: high-set start 5 to 40 percent or infinite
// - High range switch set: high-set start 1 to 8 percent or infinite
// - Switches seven and eight pick residual threshold 2, 5, 10, 20 percent
// - Infinite high-set setting disables that stage completely
`timescale 1ns/1ps
`include "earth_fault_defs.svh"

module directional_earth_fault_config
	import earth_fault_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic external_characteristic_control_i,
	input wire logic step_button_i,
	input wire logic reset_button_i,
	input wire logic low_stage_operate_i,
	input wire logic high_stage_operate_i,
	output logic trip_output_one_o,
	output logic trip_output_two_o,
	output logic sine_mode_o,
	output logic high_stage_enable_o,
	output logic [7:0] u0_threshold_o,
	output logic [7:0] low_time_setting_o,
	output logic [7:0] high_start_setting_o,
	output logic erase_records_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	logic ext_ctrl_s;
	logic step_s;
	logic reset_s;
	logic low_op_s;
	logic high_op_s;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_meta_q <= 5'h00;
			pin_sync_q <= 5'h00;
		end
		else if (ce_i)
		begin
			pin_meta_q <= {external_characteristic_control_i,
				step_button_i, reset_button_i,
				low_stage_operate_i, high_stage_operate_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign ext_ctrl_s = pin_sync_q[4];
	assign step_s = pin_sync_q[3];
	assign reset_s = pin_sync_q[2];
	assign low_op_s = pin_sync_q[1];
	assign high_op_s = pin_sync_q[0];

	////////////////////////////////////////////////////////////////////////
	// Register decode

	logic [7:0] front_selector_switch_group_q;
	setting_type setting_q;
	logic [3:0] enable_q;
	logic [3:0] status_q;
	logic wr_switch;
	logic wr_clear;
	logic wr_enable;
	logic wr_command;
	logic wr_setting;
	logic trip_latch_clear_command;

	assign wr_switch = reg_wr_i && (reg_addr_i == `OFS_SWITCH);
	assign wr_clear = reg_wr_i && (reg_addr_i == `OFS_CLEAR);
	assign wr_enable = reg_wr_i && (reg_addr_i == `OFS_ENABLE);
	assign wr_command = reg_wr_i && (reg_addr_i == `OFS_COMMAND);
	assign wr_setting = reg_wr_i && (reg_addr_i == `OFS_SETTING);
	assign trip_latch_clear_command =
		wr_command && reg_wdata_i[`CMD_LATCH_CLEAR_BIT];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			front_selector_switch_group_q <= `RST_SWITCH;
			enable_q <= `RST_ENABLE;
			setting_q <= '0;
		end
		else if (ce_i)
		begin
			if (wr_switch)
				front_selector_switch_group_q <= reg_wdata_i;
			if (wr_enable)
				enable_q <= reg_wdata_i[3:0];
			if (wr_setting && reg_addr_i[0])
				setting_q.high_start_set <= reg_wdata_i;
		end
	end

	// Raw low-time setting sits one offset above the decode read-back
	logic wr_low_time;
	assign wr_low_time = reg_wr_i && (reg_addr_i == `OFS_DECODE + 4'h1);
	logic [7:0] low_time_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			low_time_q <= `TLOW_MIN_NARROW;
		else if (ce_i && wr_low_time)
			low_time_q <= reg_wdata_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Switch decode

	logic sw_ext;
	logic sw_sin;
	logic sw_latch;
	logic sw_trange;
	logic sw_hrange;
	logic [1:0] sw_u0;
	char_mode_type char_mode;
	decode_type dec;
	logic high_infinite;
	logic [7:0] low_time_clamped;
	logic [7:0] high_start_clamped;

	assign sw_ext = front_selector_switch_group_q[`SW_EXT_BIT];
	assign sw_sin = front_selector_switch_group_q[`SW_SIN_BIT];
	assign sw_latch = front_selector_switch_group_q[`SW_LATCH_BIT];
	assign sw_trange = front_selector_switch_group_q[`SW_TRANGE_BIT];
	assign sw_hrange = front_selector_switch_group_q[`SW_HRANGE_BIT];
	assign sw_u0 = {front_selector_switch_group_q[`SW_U0_HI_BIT],
		front_selector_switch_group_q[`SW_U0_LO_BIT]};

	assign char_mode = (sw_ext ? ext_ctrl_s : sw_sin) ? CHAR_SINE
		: CHAR_COSINE;

	assign dec.u0_threshold = (sw_u0 == 2'b00) ? `U0_PCT_00
		: (sw_u0 == 2'b01) ? `U0_PCT_01
		: (sw_u0 == 2'b10) ? `U0_PCT_10
		: `U0_PCT_11;

	assign dec.low_time_min = sw_trange ? `TLOW_MIN_WIDE : `TLOW_MIN_NARROW;
	assign dec.low_time_max = sw_trange ? `TLOW_MAX_WIDE : `TLOW_MAX_NARROW;

	assign dec.high_start_min = sw_hrange ? `HSET_MIN_NARROW
		: `HSET_MIN_WIDE;
	assign dec.high_start_max = sw_hrange ? `HSET_MAX_NARROW
		: `HSET_MAX_WIDE;

	// Out-of-range settings are clamped rather than refused
	assign low_time_clamped = (low_time_q < dec.low_time_min)
		? dec.low_time_min
		: (low_time_q > dec.low_time_max) ? dec.low_time_max : low_time_q;

	assign high_infinite = (setting_q.high_start_set == `HSET_INFINITE);
	assign high_start_clamped = high_infinite ? `HSET_INFINITE
		: (setting_q.high_start_set < dec.high_start_min)
		? dec.high_start_min
		: (setting_q.high_start_set > dec.high_start_max)
		? dec.high_start_max : setting_q.high_start_set;

	////////////////////////////////////////////////////////////////////////
	// Trip latch

	logic both_buttons;
	logic both_buttons_q;
	logic button_clear;
	logic latch_clear;
	logic trip1_cause;
	logic trip2_cause;
	latch_state_type latch1_q;
	latch_state_type latch2_q;

	assign both_buttons = step_s && reset_s;
	// Edge of the button pair so a held press clears once
	assign button_clear = both_buttons && !both_buttons_q;
	assign latch_clear = button_clear || trip_latch_clear_command;
	assign trip1_cause = low_op_s;
	assign trip2_cause = high_op_s && !high_infinite;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			both_buttons_q <= 1'b0;
			latch1_q <= LATCH_IDLE;
			latch2_q <= LATCH_IDLE;
		end
		else if (ce_i)
		begin
			both_buttons_q <= both_buttons;
			case (latch1_q)
				LATCH_IDLE: if (trip1_cause && sw_latch) latch1_q <= LATCH_HELD;
				LATCH_HELD: if (latch_clear || !sw_latch) latch1_q <= LATCH_IDLE;
				default: latch1_q <= LATCH_IDLE;
			endcase
			case (latch2_q)
				LATCH_IDLE: if (trip2_cause && sw_latch) latch2_q <= LATCH_HELD;
				LATCH_HELD: if (latch_clear || !sw_latch || high_infinite)
					latch2_q <= LATCH_IDLE;
				default: latch2_q <= LATCH_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs and interrupts

	logic [3:0] events;
	logic [3:0] status_d;

	assign events = {button_clear, latch_clear, trip2_cause, trip1_cause};
	// Set wins over a clear in the same cycle
	assign status_d = (status_q & ~(wr_clear ? reg_wdata_i[3:0] : 4'h0))
		| events;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			trip_output_one_o <= 1'b0;
			trip_output_two_o <= 1'b0;
			sine_mode_o <= 1'b0;
			high_stage_enable_o <= 1'b0;
			u0_threshold_o <= `U0_PCT_00;
			low_time_setting_o <= `TLOW_MIN_NARROW;
			high_start_setting_o <= `HSET_MIN_WIDE;
			erase_records_o <= 1'b0;
			status_q <= 4'h0;
			irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			trip_output_one_o <= trip1_cause ||
				(latch1_q == LATCH_HELD && !latch_clear);
			trip_output_two_o <= trip2_cause ||
				(latch2_q == LATCH_HELD && !latch_clear && !high_infinite);
			sine_mode_o <= (char_mode == CHAR_SINE);
			high_stage_enable_o <= !high_infinite;
			u0_threshold_o <= dec.u0_threshold;
			low_time_setting_o <= low_time_clamped;
			high_start_setting_o <= high_start_clamped;
			erase_records_o <= button_clear;
			status_q <= status_d;
			irq_o <= |(status_d & enable_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port

	logic [7:0] rd_mux;

	assign rd_mux = (reg_addr_i == `OFS_SWITCH)
		? front_selector_switch_group_q
		: (reg_addr_i == `OFS_STATUS) ? {4'h0, status_q}
		: (reg_addr_i == `OFS_ENABLE) ? {4'h0, enable_q}
		: (reg_addr_i == `OFS_SETTING) ? low_time_clamped
		: (reg_addr_i == `OFS_DECODE) ? dec.u0_threshold
		: (reg_addr_i == `OFS_DECODE + 4'h1) ? low_time_q
		: 8'h00;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			reg_rdata_o <= 8'h00;
		else if (ce_i)
			reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
	end

endmodule : directional_earth_fault_config

// *** hdl/earth_fault_defs.svh ***
// Purpose: Constants for the directional earth-fault configuration block
// Assumes: Eight front selector switches, bit 0 is switch one
// Notes: Offsets are register indices on the plain register port
`ifndef EARTH_FAULT_DEFS_SVH
`define EARTH_FAULT_DEFS_SVH

// Selector switch bit positions
`define SW_DIR_BIT 0
`define SW_EXT_BIT 1
`define SW_SIN_BIT 2
`define SW_LATCH_BIT 3
`define SW_TRANGE_BIT 4
`define SW_HRANGE_BIT 5
`define SW_U0_LO_BIT 6
`define SW_U0_HI_BIT 7

// Register offsets
`define OFS_SWITCH 4'h0
`define OFS_STATUS 4'h1
`define OFS_CLEAR 4'h2
`define OFS_ENABLE 4'h3
`define OFS_COMMAND 4'h4
`define OFS_SETTING 4'h5
`define OFS_DECODE 4'h6

// Command bits
`define CMD_LATCH_CLEAR_BIT 0

// Residual voltage thresholds, percent of rated voltage
`define U0_PCT_00 8'h02
`define U0_PCT_01 8'h05
`define U0_PCT_10 8'h0a
`define U0_PCT_11 8'h14

// Low-set operate time limits, tenths of a second
`define TLOW_MIN_NARROW 8'h01
`define TLOW_MAX_NARROW 8'h0a
`define TLOW_MIN_WIDE 8'h0a
`define TLOW_MAX_WIDE 8'h64

// High-set start value limits, percent of rated current
`define HSET_MIN_WIDE 8'h05
`define HSET_MAX_WIDE 8'h28
`define HSET_MIN_NARROW 8'h01
`define HSET_MAX_NARROW 8'h08
`define HSET_INFINITE 8'hff

// Status bit positions
`define ST_TRIP1_BIT 0
`define ST_TRIP2_BIT 1
`define ST_CLEARED_BIT 2
`define ST_ERASE_BIT 3

// Reset values
`define RST_SWITCH 8'h00
`define RST_ENABLE 4'h0

`endif

// *** hdl/earth_fault_pkg.sv ***
// Purpose: Types for the directional earth-fault configuration block
// Assumes: Nothing beyond the constants header
// Notes: Types only
package earth_fault_pkg;

	typedef enum logic [1:0] {
		CHAR_COSINE = 2'b00,
		CHAR_SINE = 2'b01
	} char_mode_type;

	typedef enum logic [1:0] {
		LATCH_IDLE = 2'b00,
		LATCH_HELD = 2'b01
	} latch_state_type;

	typedef struct packed {
		logic [7:0] low_time_set;
		logic [7:0] high_start_set;
	} setting_type;

	typedef struct packed {
		logic [7:0] u0_threshold;
		logic [7:0] low_time_min;
		logic [7:0] low_time_max;
		logic [7:0] high_start_min;
		logic [7:0] high_start_max;
	} decode_type;

endpackage : earth_fault_pkg
